// file: shared/gdsc_pkg.sv
package gdsc_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLAMP_NS_PER_UNIT = 18;
  localparam int CLAMP_OFFSET_TENTHS = 55;
  localparam int CLAMP_MIN_NS = 200;
  localparam int CLAMP_MIN_CYC = (CLAMP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_UNIT_NS = 500;
  localparam int FLT_MIN_US = 10;
  localparam int FLT_MAX_MS = 500;
  localparam int FLT_UNIT_CYC = FLT_UNIT_NS / CLK_PERIOD_NS;
  localparam int FLT_MIN_UNITS = (FLT_MIN_US * 1000) / FLT_UNIT_NS;
  localparam int FLT_MAX_UNITS = (FLT_MAX_MS * 1000000) / FLT_UNIT_NS;
  localparam int FLT_CNT_W = 27;
  localparam int CARRIER_HALF_CYC = 5;
  localparam int RX_GAP_CYC = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLAMP = 8'h04;
  localparam logic [7:0] ADDR_FLT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  localparam int CTRL_OT_EN_BIT = 0;
  localparam logic [7:0] CLAMP_SET_RST = 8'h06;
  localparam logic [19:0] FLT_SET_RST = 20'h00014;
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_BOOT_BIT = 1;
  localparam int EV_CLAMP_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_START = 6'h01,
    ST_BOOT = 6'h02,
    ST_WAIT_EDGE = 6'h04,
    ST_RUN = 6'h08,
    ST_HOLD = 6'h10,
    ST_WAIT_CLR = 6'h20
  } gdsc_state_e;
endpackage

// file: rtl/gdsc_ook.sv
`timescale 1ns/1ps
module gdsc_ook #(
  parameter int HALF_CYC = gdsc_pkg::CARRIER_HALF_CYC,
  parameter int GAP_CYC = gdsc_pkg::RX_GAP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic tx_en_i,
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  output logic tx_pos_o,
  output logic tx_neg_o,
  output logic cmd_o
);
  typedef struct packed {
    logic [7:0] div;
    logic phase;
    logic tx_p;
    logic tx_n;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic diff_prev;
    logic [7:0] gap;
    logic cmd;
  } gdsc_ook_s;
  gdsc_ook_s s_r, s_nxt;
  logic diff;
  assign diff = s_r.sy2[1] & ~s_r.sy2[0];
  always_comb begin
    s_nxt = s_r;
    if (s_r.div == 8'(HALF_CYC - 1)) begin
      s_nxt.div = 8'h00;
      s_nxt.phase = ~s_r.phase;
    end else begin
      s_nxt.div = s_r.div + 8'h01;
    end
    // Complementary carrier, both low when keyed off
    s_nxt.tx_p = tx_en_i & s_r.phase;
    s_nxt.tx_n = tx_en_i & ~s_r.phase;
    s_nxt.sy1 = {rx_pos_i, rx_neg_i};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.diff_prev = diff;
    // Carrier present while edges keep coming
    if (diff != s_r.diff_prev) begin
      s_nxt.gap = 8'h00;
    end else if (s_r.gap != 8'(GAP_CYC)) begin
      s_nxt.gap = s_r.gap + 8'h01;
    end
    s_nxt.cmd = (s_nxt.gap != 8'(GAP_CYC));
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
      s_r.gap <= 8'(GAP_CYC);
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tx_pos_o = s_r.tx_p;
  assign tx_neg_o = s_r.tx_n;
  assign cmd_o = s_r.cmd;
  keyed_off_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !tx_en_i |=> !s_r.tx_p && !s_r.tx_n) else $error("carrier sent while keyed off");
  carrier_compl_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    tx_en_i |=> s_r.tx_p != s_r.tx_n) else $error("carrier outputs not complementary");
endmodule // gdsc_ook

// file: rtl/gdsc_top.sv
`timescale 1ns/1ps
// Contract
// - Select pin low picks transformer link, high picks digital pins; only that mode acts.
// - Digital fault pins: 1/0 no fault, 0/1 fault, 0/0 during start-up.
// - Modulated mode sends carrier only with no fault; none in fault or start-up.
// - Fault status keys an internal carrier onto two complementary transmit outputs.
// - Receiver demodulates the incoming differential pair into the PWM command.
// - Fault while command high turns output off through the graceful-off switch.
// - Clamp output drives an external transistor holding the gate at negative rail.
// - Clamp delay is 18 ns per setting unit plus 5.5 units offset.
// - Clamp delay never below 200 ns.
// - Start-up runs the fault timer with output off so bootstrap capacitors charge.
// - A command held high keeps the upper driver on indefinitely.
// - Undervoltage, power-good, desaturation and optional overtemperature merge into one fault.
// - Combined fault is latched for the fault-timer period, output held off.
// - After the latch period with fault gone, resume on next command rising edge.
module gdsc_top #(
  parameter int ADDR_W = 8,
  parameter int FLT_UNIT_CYC = gdsc_pkg::FLT_UNIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic interface_select_i,
  input wire logic pwm_digital_i,
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  input wire logic uvlo_fault_i,
  input wire logic power_good_i,
  input wire logic desat_fault_i,
  input wire logic overtemp_fault_i,
  output logic fault_out_pos_o,
  output logic fault_out_neg_o,
  output logic upper_driver_o,
  output logic lower_driver_o,
  output logic graceful_off_switch_o,
  output logic clamp_drive_out_o,
  output logic irq_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    gdsc_pkg::gdsc_state_e st;
    logic [5:0] sy1;
    logic [5:0] sy2;
    logic cmd_prev;
    logic graceful_off_switch;
    logic [15:0] clamp_cnt;
    logic [gdsc_pkg::FLT_CNT_W-1:0] flt_cnt;
    logic ot_en;
    logic [7:0] clamp_set;
    logic [19:0] flt_set;
    logic [2:0] ist;
    logic [2:0] imask;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic up;
    logic lo;
    logic ssd_o;
    logic clamp_o;
    logic fpos;
    logic fneg;
    logic tx_en;
    logic irq;
  } gdsc_top_s;
  gdsc_top_s s_r, s_nxt;

  function automatic logic [15:0] clamp_cycles(input logic [7:0] set);
    int tenths_ns;
    int cyc;
    tenths_ns = gdsc_pkg::CLAMP_NS_PER_UNIT * (10 * int'(set) + gdsc_pkg::CLAMP_OFFSET_TENTHS);
    cyc = (tenths_ns + 10 * gdsc_pkg::CLK_PERIOD_NS - 1) / (10 * gdsc_pkg::CLK_PERIOD_NS);
    if (cyc < gdsc_pkg::CLAMP_MIN_CYC) begin
      cyc = gdsc_pkg::CLAMP_MIN_CYC;
    end
    return 16'(cyc);
  endfunction

  function automatic logic [gdsc_pkg::FLT_CNT_W-1:0] flt_cycles(input logic [19:0] units);
    int u;
    u = int'(units);
    if (u < gdsc_pkg::FLT_MIN_UNITS) begin
      u = gdsc_pkg::FLT_MIN_UNITS;
    end
    if (u > gdsc_pkg::FLT_MAX_UNITS) begin
      u = gdsc_pkg::FLT_MAX_UNITS;
    end
    return gdsc_pkg::FLT_CNT_W'(u * FLT_UNIT_CYC - 1);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic demod_cmd, mod_p, mod_n, sel, fault, cmd, rise, startup, faulted;
  logic [15:0] ccyc;
  assign sel = s_r.sy2[5];
  // Merged fault, overtemperature only when enabled
  assign fault = s_r.sy2[3] | ~s_r.sy2[2] | s_r.sy2[1] | (s_r.sy2[0] & s_r.ot_en);
  // Only the selected interface feeds the data path
  assign cmd = sel ? s_r.sy2[4] : demod_cmd;
  assign rise = cmd & ~s_r.cmd_prev;
  assign ccyc = clamp_cycles(s_r.clamp_set);
  assign startup = (s_r.st == gdsc_pkg::ST_START) || (s_r.st == gdsc_pkg::ST_BOOT);
  assign faulted = (s_r.st == gdsc_pkg::ST_HOLD) || (s_r.st == gdsc_pkg::ST_WAIT_CLR);

  gdsc_ook u_ook (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tx_en_i(s_r.tx_en),
    .rx_pos_i(rx_pos_i),
    .rx_neg_i(rx_neg_i),
    .tx_pos_o(mod_p),
    .tx_neg_o(mod_n),
    .cmd_o(demod_cmd)
  );

  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] wd;
    logic nofault_n, fault_n, start_n;
    ev = 3'h0;
    clr = 3'h0;
    wd = 32'h0;
    nofault_n = 1'b0;
    fault_n = 1'b0;
    start_n = 1'b0;
    s_nxt = s_r;
    s_nxt.sy1 = {interface_select_i, pwm_digital_i, uvlo_fault_i, power_good_i, desat_fault_i, overtemp_fault_i};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.cmd_prev = cmd;
    if (s_r.flt_cnt != '0) begin
      s_nxt.flt_cnt = s_r.flt_cnt - 1'b1;
    end
    case (s_r.st)
      gdsc_pkg::ST_START: begin
        if (!fault) begin
          s_nxt.st = gdsc_pkg::ST_BOOT;
          s_nxt.flt_cnt = flt_cycles(s_r.flt_set);
        end
      end
      gdsc_pkg::ST_BOOT: begin
        if (fault) begin
          s_nxt.st = gdsc_pkg::ST_START;
        end else if (s_r.flt_cnt == '0) begin
          s_nxt.st = gdsc_pkg::ST_WAIT_EDGE;
          ev[gdsc_pkg::EV_BOOT_BIT] = 1'b1;
        end
      end
      gdsc_pkg::ST_WAIT_EDGE, gdsc_pkg::ST_RUN: begin
        if (fault) begin
          // Graceful off only when the output was on
          s_nxt.st = gdsc_pkg::ST_HOLD;
          s_nxt.graceful_off_switch = (s_r.st == gdsc_pkg::ST_RUN) && cmd;
          s_nxt.flt_cnt = flt_cycles(s_r.flt_set);
          ev[gdsc_pkg::EV_FAULT_BIT] = 1'b1;
        end else if (rise) begin
          s_nxt.st = gdsc_pkg::ST_RUN;
        end
      end
      gdsc_pkg::ST_HOLD: begin
        if (s_r.flt_cnt == '0) begin
          s_nxt.st = fault ? gdsc_pkg::ST_WAIT_CLR : gdsc_pkg::ST_WAIT_EDGE;
          s_nxt.graceful_off_switch = fault & s_r.graceful_off_switch;
        end
      end
      gdsc_pkg::ST_WAIT_CLR: begin
        if (!fault) begin
          s_nxt.st = gdsc_pkg::ST_WAIT_EDGE;
          s_nxt.graceful_off_switch = 1'b0;
        end
      end
      default: begin
        s_nxt.st = gdsc_pkg::ST_START;
      end
    endcase
    // Clamp delay counts from the command falling edge
    if (s_nxt.st != gdsc_pkg::ST_RUN || cmd) begin
      s_nxt.clamp_cnt = 16'h0000;
    end else if (s_r.clamp_cnt < ccyc) begin
      s_nxt.clamp_cnt = s_r.clamp_cnt + 16'h0001;
    end
    s_nxt.clamp_o = (s_nxt.st == gdsc_pkg::ST_RUN) && !cmd && (s_nxt.clamp_cnt >= ccyc);
    if (s_nxt.clamp_o && !s_r.clamp_o) begin
      ev[gdsc_pkg::EV_CLAMP_BIT] = 1'b1;
    end
    start_n = (s_nxt.st == gdsc_pkg::ST_START) || (s_nxt.st == gdsc_pkg::ST_BOOT);
    fault_n = (s_nxt.st == gdsc_pkg::ST_HOLD) || (s_nxt.st == gdsc_pkg::ST_WAIT_CLR);
    nofault_n = !start_n && !fault_n;
    // Full duty is simply a command that never falls
    s_nxt.up = (s_nxt.st == gdsc_pkg::ST_RUN) && cmd;
    s_nxt.ssd_o = start_n || (fault_n && s_nxt.graceful_off_switch);
    s_nxt.lo = !s_nxt.up && !s_nxt.ssd_o;
    s_nxt.tx_en = !sel && nofault_n;
    // Modulator output is retimed so both pins leave flops
    s_nxt.fpos = sel ? nofault_n : mod_p;
    s_nxt.fneg = sel ? fault_n : mod_n;
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_held && s_nxt.w_held && !s_nxt.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = gdsc_pkg::RESP_OKAY;
      case (8'(s_nxt.awaddr))
        gdsc_pkg::ADDR_CTRL: begin
          wd = merge({31'h0, s_r.ot_en}, s_nxt.wdata, s_nxt.wstrb);
          s_nxt.ot_en = wd[gdsc_pkg::CTRL_OT_EN_BIT];
        end
        gdsc_pkg::ADDR_CLAMP: begin
          wd = merge({24'h0, s_r.clamp_set}, s_nxt.wdata, s_nxt.wstrb);
          s_nxt.clamp_set = wd[7:0];
        end
        gdsc_pkg::ADDR_FLT: begin
          wd = merge({12'h0, s_r.flt_set}, s_nxt.wdata, s_nxt.wstrb);
          s_nxt.flt_set = wd[19:0];
        end
        gdsc_pkg::ADDR_STATUS: begin
        end
        gdsc_pkg::ADDR_ISTAT: begin
          wd = merge(32'h0, s_nxt.wdata, s_nxt.wstrb);
          clr = wd[2:0];
        end
        gdsc_pkg::ADDR_IMASK: begin
          wd = merge({29'h0, s_r.imask}, s_nxt.wdata, s_nxt.wstrb);
          s_nxt.imask = wd[2:0];
        end
        default: begin
          s_nxt.bresp = gdsc_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = gdsc_pkg::RESP_OKAY;
      case (8'(s_axi_araddr))
        gdsc_pkg::ADDR_CTRL: s_nxt.rdata = {31'h0, s_r.ot_en};
        gdsc_pkg::ADDR_CLAMP: s_nxt.rdata = {24'h0, s_r.clamp_set};
        gdsc_pkg::ADDR_FLT: s_nxt.rdata = {12'h0, s_r.flt_set};
        gdsc_pkg::ADDR_STATUS: s_nxt.rdata = {21'h0, cmd, fault, sel, s_r.clamp_o, s_r.up, s_r.st};
        gdsc_pkg::ADDR_ISTAT: s_nxt.rdata = {29'h0, s_r.ist};
        gdsc_pkg::ADDR_IMASK: s_nxt.rdata = {29'h0, s_r.imask};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = gdsc_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;
    // New event beats a same-cycle clear
    s_nxt.ist = (s_r.ist & ~clr) | ev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
      s_r.st <= gdsc_pkg::ST_START;
      s_r.sy1[2] <= 1'b0;
      s_r.clamp_set <= gdsc_pkg::CLAMP_SET_RST;
      s_r.flt_set <= gdsc_pkg::FLT_SET_RST;
      s_r.ssd_o <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fault_out_pos_o = s_r.fpos;
  assign fault_out_neg_o = s_r.fneg;
  assign upper_driver_o = s_r.up;
  assign lower_driver_o = s_r.lo;
  assign graceful_off_switch_o = s_r.ssd_o;
  assign clamp_drive_out_o = s_r.clamp_o;
  assign irq_o = s_r.irq;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Digital-mode pins are built from the next state, so they match the state register in the same cycle
  dig_startup_a: assert property (sel && startup |-> !s_r.fpos && !s_r.fneg)
    else $error("startup pins not 0/0");
  dig_fault_a: assert property (sel && $stable(sel) && faulted |-> !s_r.fpos && s_r.fneg)
    else $error("fault pins not 0/1");
  mod_silent_a: assert property ((!sel && !(s_r.st inside {gdsc_pkg::ST_WAIT_EDGE, gdsc_pkg::ST_RUN}))[*4]
    |-> !s_r.fpos && !s_r.fneg) else $error("carrier sent during fault or startup");
  mod_energy_a: assert property ((!sel && (s_r.st inside {gdsc_pkg::ST_WAIT_EDGE, gdsc_pkg::ST_RUN}))[*4]
    |-> s_r.fpos != s_r.fneg) else $error("no complementary carrier without fault");
  soft_off_a: assert property (s_r.st == gdsc_pkg::ST_RUN && fault && cmd
    |=> s_r.ssd_o && !s_r.up && !s_r.lo) else $error("fault not taken by graceful off");
  clamp_min_a: assert property (ccyc >= 16'(gdsc_pkg::CLAMP_MIN_CYC))
    else $error("clamp delay below minimum");
  clamp_delay_a: assert property ($rose(s_r.clamp_o) |-> s_r.clamp_cnt == ccyc)
    else $error("clamp asserted before its delay");
  clamp_drop_a: assert property (rise |=> !s_r.clamp_o)
    else $error("clamp held over rising command");
  held_off_a: assert property (s_r.st != gdsc_pkg::ST_RUN |-> !s_r.up)
    else $error("upper driver on outside normal run");
  boot_off_a: assert property (s_r.st == gdsc_pkg::ST_BOOT |-> s_r.ssd_o && !s_r.lo)
    else $error("output not held off during startup timer");
  resume_a: assert property ($rose(s_r.st == gdsc_pkg::ST_RUN) |-> $past(rise))
    else $error("resumed without a rising command");
  full_duty_a: assert property ((s_r.st == gdsc_pkg::ST_RUN && !fault && cmd)[*3] |-> s_r.up)
    else $error("upper driver dropped under held command");
  irq_level_a: assert property (s_r.irq == |(s_r.ist & s_r.imask))
    else $error("interrupt level mismatch");
  resume_c: cover property ($rose(s_r.st == gdsc_pkg::ST_RUN));
  fault_c: cover property (s_r.st == gdsc_pkg::ST_RUN ##1 s_r.st == gdsc_pkg::ST_HOLD && s_r.graceful_off_switch);
  clamp_c: cover property ($rose(s_r.clamp_o));
  retry_c: cover property (s_r.st == gdsc_pkg::ST_WAIT_CLR ##1 s_r.st == gdsc_pkg::ST_WAIT_EDGE);
endmodule // gdsc_top

// file: dv/gdsc_primary_model.sv
`timescale 1ns/1ps
module gdsc_primary_model (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic cmd_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  output logic rx_pos_o,
  output logic rx_neg_o,
  output logic energy_ok_o
);
  // A little over two carrier periods, so one late edge is not a fault
  localparam int LOSS_CYC = 24;
  logic [2:0] ph_r;
  logic [5:0] gap_r;
  logic tx_pos_r;
  // Carrier keyed by the command; both lines rest low with no energy
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !cmd_i) begin
      ph_r <= 3'h0;
      rx_pos_o <= 1'b0;
      rx_neg_o <= 1'b0;
    end else if (ph_r == 3'h4) begin
      ph_r <= 3'h0;
      rx_pos_o <= !rx_pos_o;
      rx_neg_o <= rx_pos_o;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end
  // Any gap of LOSS_CYC cycles or more in received energy counts as a fault, whatever its cause
  always_ff @(posedge clk_sys_i) begin
    tx_pos_r <= tx_pos_i;
    if (!reset_n_i) begin
      gap_r <= 6'h3F;
    end else if (tx_pos_i && !tx_pos_r && !tx_neg_i) begin
      gap_r <= 6'h00;
    end else if (gap_r != 6'h3F) begin
      gap_r <= gap_r + 6'h01;
    end
  end
  assign energy_ok_o = (gap_r < 6'(LOSS_CYC));
endmodule // gdsc_primary_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  // Whole sequence needs under two thousand cycles
  localparam int TIMEOUT_CYC = 20000;
  localparam logic [1:0] OK = gdsc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gdsc_pkg::RESP_SLVERR;
  logic clk;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic pwm = 1'b0;
  logic pcmd = 1'b0;
  // Fault pins: uvlo, power good, desat, overtemp; power good high is healthy
  logic [3:0] flt = 4'h2;
  logic rxp, rxn, fpos, fneg, up, lo, gr, cl, irq, eok;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] pins;
  logic [7:0] cs [3] = '{8'h00, 8'h0A, 8'hC8};
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_n = 0;
  int ex;
  // Pin order: fault pos, fault neg, upper, lower, graceful, clamp, irq
  assign pins = {fpos, fneg, up, lo, gr, cl, irq};

  gdsc_top #(.FLT_UNIT_CYC(1)) u_gdsc_top (
    .clk_sys_i(clk), .reset_n_i(rst_n), .interface_select_i(sel), .pwm_digital_i(pwm),
    .rx_pos_i(rxp), .rx_neg_i(rxn), .uvlo_fault_i(flt[0]), .power_good_i(flt[1]),
    .desat_fault_i(flt[2]), .overtemp_fault_i(flt[3]), .fault_out_pos_o(fpos),
    .fault_out_neg_o(fneg), .upper_driver_o(up), .lower_driver_o(lo), .graceful_off_switch_o(gr),
    .clamp_drive_out_o(cl), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  gdsc_primary_model u_gdsc_primary_model (.clk_sys_i(clk), .reset_n_i(rst_n), .cmd_i(pcmd),
    .tx_pos_i(fpos), .tx_neg_i(fneg), .rx_pos_o(rxp), .rx_neg_o(rxn), .energy_ok_o(eok));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == TIMEOUT_CYC) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic pin(input string nm, input logic [6:0] e);
    chk(nm, 32'(e), 32'(pins));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata & m);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    sel <= s;
    cyc(10);
    rst_n <= 1'b1;
  endtask

  task automatic rise();
    pwm <= 1'b0;
    cyc(4);
    pwm <= 1'b1;
    cyc(6);
  endtask

  initial begin
    do_reset(1'b1);
    pwm <= 1'b1;
    cyc(10);
    pin("startup", 7'h04);
    rd(gdsc_pkg::ADDR_CTRL, 32'h0, 32'hFFFFFFFF, OK);
    rd(gdsc_pkg::ADDR_CLAMP, 32'h6, 32'hFFFFFFFF, OK);
    rd(gdsc_pkg::ADDR_FLT, 32'h14, 32'hFFFFFFFF, OK);
    rd(gdsc_pkg::ADDR_IMASK, 32'h0, 32'hFFFFFFFF, OK);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, ERR);
    wr(8'h1C, 32'h1, ERR);
    cyc(20);
    pin("wait edge", 7'h48);
    rd(gdsc_pkg::ADDR_ISTAT, 32'h2, 32'h2, OK);
    wr(gdsc_pkg::ADDR_ISTAT, 32'h7, OK);
    rise();
    pin("run", 7'h50);
    rd(gdsc_pkg::ADDR_STATUS, 32'h48, 32'h7F, OK);
    wr(gdsc_pkg::ADDR_STATUS, 32'h0, OK);
    cyc(200);
    pin("full duty", 7'h50);
    $display("test startup done");
    // Low time of the command always exceeds the clamp delay
    foreach (cs[k]) begin
      ex = (9 * (2 * int'(cs[k]) + 11) + 4) / 5;
      if (ex < 40) ex = 40;
      wr(gdsc_pkg::ADDR_CLAMP, {24'h0, cs[k]}, OK);
      pwm <= 1'b0;
      cyc(ex - 2);
      chk("clamp early", 32'h0, 32'(cl));
      cyc(8);
      pin("clamp on", 7'h4A);
      pwm <= 1'b1;
      cyc(5);
      pin("clamp off", 7'h50);
    end
    rd(gdsc_pkg::ADDR_ISTAT, 32'h4, 32'h4, OK);
    $display("test clamp done");
    wr(gdsc_pkg::ADDR_CTRL, 32'h1, OK);
    wr(gdsc_pkg::ADDR_IMASK, 32'h1, OK);
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h2 ^ (4'h1 << i);
      cyc(6);
      pin("fault", 7'h25);
      wr(gdsc_pkg::ADDR_IMASK, 32'h0, OK);
      cyc(2);
      pin("masked", 7'h24);
      flt <= 4'h2;
      wr(gdsc_pkg::ADDR_IMASK, 32'h1, OK);
      cyc(2);
      pin("held", 7'h25);
      cyc(20);
      pin("released", 7'h49);
      wr(gdsc_pkg::ADDR_ISTAT, 32'h1, OK);
      cyc(2);
      pin("cleared", 7'h48);
      rise();
      pin("resumed", 7'h50);
    end
    wr(gdsc_pkg::ADDR_CTRL, 32'h0, OK);
    flt <= 4'hA;
    cyc(8);
    pin("overtemp off", 7'h50);
    flt <= 4'h2;
    $display("test fault done");
    do_reset(1'b0);
    cyc(10);
    chk("startup quiet", 32'h0, 32'(eok));
    cyc(40);
    chk("energy", 32'h1, 32'(eok));
    chk("complement", 32'h1, 32'(fpos ^ fneg));
    pcmd <= 1'b1;
    pwm <= 1'b0;
    cyc(40);
    chk("demod on", 32'h1, 32'(up));
    pcmd <= 1'b0;
    pwm <= 1'b1;
    cyc(40);
    chk("demod off", 32'h0, 32'(up));
    flt <= 4'h6;
    cyc(40);
    chk("fault quiet", 32'h0, 32'(eok));
    chk("no carrier", 32'h0, 32'(fpos | fneg));
    flt <= 4'h2;
    $display("test link done");
    summarize();
  end
endmodule // tb
